// ---- hw/pwrs_ctl.sv ----
// Function
// - phy held in reset at least 2 ms
// - reset request bit self-clears, resets to zero
// - writes to request bit ignored while set
// - usb transfers answered nak during reset
// - bit 3 enables lan wake source
// - bit 2 enables energy detect wake
// - remote resume clears enables when control bit set
// - two-bit wake cause field, resets zero
// - status bits set and cleared independently
// - write one clears status bit
// - low status bit means energy detect wake
// - only remote-started resume clears enables
// - resume clears high status when enabled
`include "pwrs_params.svh"

module pwrs_ctl
    import pwrs_pkg::*;
#(
    parameter int HOLD_CYC = `PWRS_HOLD_CYC
) (
    input  wire logic       mclk,        // 50 MHz system clock
    input  wire logic       rst,         // async reset, active high
    input  wire logic [7:0] addr,        // register byte address
    input  wire logic [31:0] wdata,      // write data
    input  wire logic       wr,          // write strobe
    input  wire logic       rd,          // read strobe
    output logic [31:0]     rdata,       // read data, cycle after rd
    input  wire logic       lanWake,     // lan wake event, async
    input  wire logic       energyWake,  // energy detect event, async
    input  wire logic       resumeDone,  // resume complete pulse
    input  wire logic       resumeRemote, // resume was remote started
    output logic            phyRst,      // phy reset, active high
    output logic            usbNak,      // nak all usb transfers
    output logic            lanWakeEn,   // lan wake enable
    output logic            edWakeEn     // energy detect wake enable
);

    pwrs_req_t  req;        // bundled register request
    pwrs_wake_t wk;         // bundled wake inputs

    logic [1:0] lanSyncQ;   // two-stage synchroniser, lan wake
    logic [1:0] edSyncQ;    // two-stage synchroniser, energy
    logic       lanEnQ, lanEnD;
    logic       edEnQ, edEnD;
    logic [1:0] stsQ, stsD;        // wake cause status
    logic       rclrEnQ, rclrEnD;  // resume clears enables
    logic       rclrStsQ, rclrStsD; // resume clears status
    logic [31:0] rdataQ, rdataD;
    logic       nakQ;
    logic       phyQ;
    logic       rstBusy;    // request bit as read
    logic       phyRaw;     // reset from sequencer
    logic       rstStart;   // accepted request pulse
    logic       ctlWr;      // write hits control register

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign wk  = '{lanWake: lanSyncQ[1], energyWake: edSyncQ[1],
                   resumeDone: resumeDone, resumeRemote: resumeRemote};

    // single decode point for the one register
    function automatic logic hit(input logic [7:0] a);
        hit = (a == `PWRS_CTL_ADDR);
    endfunction : hit

    assign ctlWr    = req.wr && hit(req.addr);
    // a set request while busy is dropped, not queued
    assign rstStart = ctlWr && req.wdata[`PWRS_BIT_PHYRST] && !rstBusy;

    // phy reset sequencer
    pwrs_phy_reset #(
        .HOLD_CYC (HOLD_CYC)
    ) u_phy_reset (
        .mclk   (mclk),
        .rst    (rst),
        .start  (rstStart),
        .busy   (rstBusy),
        .phyRst (phyRaw)
    );

    // synchronise asynchronous wake sources
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lanSyncQ <= 2'h0;
            edSyncQ  <= 2'h0;
        end else begin
            lanSyncQ <= {lanSyncQ[0], lanWake};
            edSyncQ  <= {edSyncQ[0], energyWake};
        end
    end

    // next values for the control and status fields
    always_comb begin
        lanEnD   = lanEnQ;
        edEnD    = edEnQ;
        stsD     = stsQ;
        rclrEnD  = rclrEnQ;
        rclrStsD = rclrStsQ;
        // software writes first; hardware events below take priority
        if (ctlWr) begin
            lanEnD   = req.wdata[`PWRS_BIT_LANEN];
            edEnD    = req.wdata[`PWRS_BIT_EDEN];
            rclrEnD  = req.wdata[`PWRS_BIT_RCLREN];
            rclrStsD = req.wdata[`PWRS_BIT_RCLRSTS];
            // write one clears, zero leaves alone, per bit
            if (req.wdata[`PWRS_BIT_WSTS0]) begin
                stsD[0] = 1'b0;
            end
            if (req.wdata[`PWRS_BIT_WSTS1]) begin
                stsD[1] = 1'b0;
            end
        end
        // resume completion actions
        if (wk.resumeDone) begin
            // host-started resume leaves enables intact
            if (rclrEnQ && wk.resumeRemote) begin
                lanEnD = 1'b0;
                edEnD  = 1'b0;
            end
            if (rclrStsQ) begin
                stsD[1] = 1'b0;
            end
        end
        // wake events set status; set wins over any clear
        if (wk.energyWake && edEnQ) begin
            stsD[0] = 1'b1;
        end
        if (wk.lanWake && lanEnQ) begin
            stsD[1] = 1'b1;
        end
    end

    // readback mux, answered one cycle after the strobe
    always_comb begin
        rdataD = 32'h0000_0000;
        if (req.rd) begin
            if (hit(req.addr)) begin
                rdataD[`PWRS_BIT_WSTS1:`PWRS_BIT_WSTS0] = stsQ;
                rdataD[`PWRS_BIT_EDEN]    = edEnQ;
                rdataD[`PWRS_BIT_LANEN]   = lanEnQ;
                rdataD[`PWRS_BIT_PHYRST]  = rstBusy;
                rdataD[`PWRS_BIT_RCLREN]  = rclrEnQ;
                rdataD[`PWRS_BIT_RCLRSTS] = rclrStsQ;
            end else begin
                rdataD = 32'h0000_0000;   // unmapped reads zero
            end
        end
    end

    // register stage for fields, readback and outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lanEnQ   <= 1'b0;
            edEnQ    <= 1'b0;
            stsQ     <= 2'h0;
            rclrEnQ  <= `PWRS_RST_RCLREN;
            rclrStsQ <= `PWRS_RST_RCLRSTS;
            rdataQ   <= 32'h0000_0000;
            nakQ     <= 1'b0;
            phyQ     <= 1'b0;
        end else begin
            lanEnQ   <= lanEnD;
            edEnQ    <= edEnD;
            stsQ     <= stsD;
            rclrEnQ  <= rclrEnD;
            rclrStsQ <= rclrStsD;
            rdataQ   <= rdataD;
            // nak covers the whole time the request bit is set
            nakQ     <= rstStart | (rstBusy & ~(phyQ & ~phyRaw)) | phyRaw;
            phyQ     <= phyRaw | rstStart;
        end
    end

    assign rdata     = rdataQ;
    assign usbNak    = nakQ;
    assign phyRst    = phyQ;
    assign lanWakeEn = lanEnQ;
    assign edWakeEn  = edEnQ;

endmodule : pwrs_ctl

// ---- hw/pwrs_params.svh ----
`ifndef PWRS_PARAMS_SVH
`define PWRS_PARAMS_SVH

// register offset (byte address on the plain register port)
`define PWRS_CTL_ADDR      8'h20
// field positions inside the control register
`define PWRS_BIT_WSTS0     0
`define PWRS_BIT_WSTS1     1
`define PWRS_BIT_EDEN      2
`define PWRS_BIT_LANEN     3
`define PWRS_BIT_PHYRST    4
`define PWRS_BIT_RCLREN    8
`define PWRS_BIT_RCLRSTS   9
// reset values
`define PWRS_RST_RCLREN    1'b1
`define PWRS_RST_RCLRSTS   1'b0
// timing
`define PWRS_CLK_HZ        50000000
`define PWRS_HOLD_US       2000
`define PWRS_HOLD_CYC      ((`PWRS_CLK_HZ / 1000000) * `PWRS_HOLD_US)

`endif

// ---- hw/pwrs_phy_reset.sv ----
`include "pwrs_params.svh"

module pwrs_phy_reset
    import pwrs_pkg::*;
#(
    parameter int HOLD_CYC = `PWRS_HOLD_CYC
) (
    input  wire logic mclk,     // system clock
    input  wire logic rst,      // async reset
    input  wire logic start,    // one-cycle request
    output logic      busy,     // request bit view
    output logic      phyRst    // reset to phy
);

    localparam int CW = $clog2(HOLD_CYC + 1);

    pwrs_rst_state_t stateQ, stateD;  // sequencer state
    logic [CW-1:0]   cntQ, cntD;      // hold counter
    logic            busyQ, busyD;
    logic            phyQ, phyD;

    // next state: hold for full count, then release one cycle
    always_comb begin
        stateD = stateQ;
        cntD   = cntQ;
        busyD  = busyQ;
        phyD   = phyQ;
        case (stateQ)
            PR_IDLE: begin
                if (start) begin
                    stateD = PR_HOLD;
                    cntD   = CW'(HOLD_CYC - 1);
                    busyD  = 1'b1;
                    phyD   = 1'b1;
                end
            end
            PR_HOLD: begin
                // counting down keeps phy reset high at least the hold time
                if (cntQ == '0) begin
                    stateD = PR_REL;
                    phyD   = 1'b0;
                end else begin
                    cntD = cntQ - CW'(1);
                end
            end
            PR_REL: begin
                // bit drops only after phy has been released
                stateD = PR_IDLE;
                busyD  = 1'b0;
            end
            default: begin
                stateD = PR_IDLE;
            end
        endcase
    end

    // registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateQ <= PR_IDLE;
            cntQ   <= '0;
            busyQ  <= 1'b0;
            phyQ   <= 1'b0;
        end else begin
            stateQ <= stateD;
            cntQ   <= cntD;
            busyQ  <= busyD;
            phyQ   <= phyD;
        end
    end

    assign busy   = busyQ;
    assign phyRst = phyQ;

endmodule : pwrs_phy_reset

// ---- hw/pwrs_pkg.sv ----
package pwrs_pkg;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pwrs_req_t;

    // phy reset sequencer states
    typedef enum logic [1:0] {
        PR_IDLE = 2'b00,
        PR_HOLD = 2'b01,
        PR_REL  = 2'b10
    } pwrs_rst_state_t;

    // wake sources and resume events from the suspend logic
    typedef struct packed {
        logic lanWake;       // wake on lan detected
        logic energyWake;    // energy detected on line
        logic resumeDone;    // resume sequence completed
        logic resumeRemote;  // that resume was remote started
    } pwrs_wake_t;

endpackage : pwrs_pkg

// ---- tb/pwrs_ctl_bench.sv ----
`include "pwrs_params.svh"

module pwrs_ctl_bench
    import pwrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A = `PWRS_CTL_ADDR; // control register
    logic        mclk = 0, rst = 1, wr = 0, rd = 0;
    logic        fireLan = 0, fireEd = 0, fireRes = 0, remote = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic        phyRst, usbNak, lanWakeEn, edWakeEn;
    pwrs_wake_t  wk;
    int          mismatches = 0, check_count = 0, n;

    pwrs_ctl #(.HOLD_CYC(8)) u_dut (.*, .lanWake(wk.lanWake),
        .energyWake(wk.energyWake), .resumeDone(wk.resumeDone),
        .resumeRemote(wk.resumeRemote));
    pwrs_wake_model u_wake (.*);

    initial forever #10 mclk = ~mclk;

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wrReg(logic [7:0] a, logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wrReg
    // read data stand only in the cycle after the strobe
    task automatic rdChk(logic [7:0] a, logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 check("rdata", rdata, exp);
    endtask : rdChk
    // event request, then time for sync and status update
    task automatic pulse(logic [2:0] f, logic r);
        @(posedge mclk);
        {fireLan, fireEd, fireRes} <= f;
        remote <= r;
        @(posedge mclk);
        {fireLan, fireEd, fireRes} <= 3'h0;
        repeat (6) @(posedge mclk);
    endtask : pulse
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rdChk(A, 32'h0000_0100);
        wrReg(A, 32'h0000_0110);
        #1 check("nak", 32'(usbNak & phyRst), 32'h0000_0001);
        rdChk(A, 32'h0000_0110);
        wrReg(A, 32'h0000_0110); // retry while busy is dropped
        n = 5;
        repeat (40) begin
            @(posedge mclk);
            #1;
            if (phyRst !== 1'b1) break;
            n++;
        end
        // hold count plus the one release cycle before the bit drops
        check("hold", 32'(n), 32'h0000_0009);
        check("nakTail", 32'(usbNak), 32'h0000_0000);
        if (n > 40) end_of_test();
        rdChk(A, 32'h0000_0100);
        pulse(3'h6, 1'b0);
        rdChk(A, 32'h0000_0100);
        wrReg(A, 32'h0000_010C);
        #1 check("en", 32'({lanWakeEn, edWakeEn}), 32'h0000_0003);
        pulse(3'h2, 1'b0);
        rdChk(A, 32'h0000_010D);
        pulse(3'h4, 1'b0);
        rdChk(A, 32'h0000_010F);
        wrReg(A, 32'h0000_010E);
        rdChk(A, 32'h0000_010D);
        pulse(3'h1, 1'b0);
        rdChk(A, 32'h0000_010D);
        pulse(3'h1, 1'b1);
        rdChk(A, 32'h0000_0101);
        check("en", 32'({lanWakeEn, edWakeEn}), 32'h0000_0000);
        wrReg(A, 32'h0000_020C);
        pulse(3'h4, 1'b0);
        rdChk(A, 32'h0000_020F);
        pulse(3'h1, 1'b1);
        rdChk(A, 32'h0000_020D);
        wrReg(A, 32'h0000_020D);
        rdChk(A, 32'h0000_020C);
        wrReg(8'h24, 32'hFFFF_FFFF);
        rdChk(8'h24, 32'h0000_0000);
        rdChk(A, 32'h0000_020C);
        end_of_test();
    end
endmodule : pwrs_ctl_bench

// ---- tb/pwrs_ctl_properties.sv ----
`include "pwrs_params.svh"

module pwrs_ctl_props
    import pwrs_pkg::*;
#(
    parameter int HOLD_CYC = 8
) (
    input wire logic        mclk,         // clock
    input wire logic        rst,          // reset
    input wire logic [7:0]  addr,         // address
    input wire logic [31:0] wdata,        // write data
    input wire logic        wr,           // write strobe
    input wire logic        resumeDone,   // resume pulse
    input wire logic        resumeRemote, // resume kind
    input wire logic        phyRst,       // phy reset
    input wire logic        usbNak,       // nak flag
    input wire logic        lanWakeEn,    // lan enable
    input wire logic        edWakeEn      // energy enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    int hiCnt; // length of current reset pulse
    // counts high cycles so the hold needs no long repetition
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hiCnt <= 0;
        end else begin
            hiCnt <= phyRst ? hiCnt + 1 : 0;
        end
    end
    a_nak_covers: assert property (phyRst |-> usbNak)
        else $error("nak low during phy reset");
    a_hold_min: assert property ($fell(phyRst) |-> hiCnt >= HOLD_CYC)
        else $error("phy reset released early");
    a_rst_cause: assert property ($rose(phyRst) |->
        $past(wr && addr == `PWRS_CTL_ADDR && wdata[4]))
        else $error("phy reset without request");
    a_nak_release: assert property ($fell(phyRst) |-> !usbNak && $past(usbNak))
        else $error("nak end misplaced");
    a_no_retrigger: assert property ($rose(phyRst) |-> !$past(usbNak))
        else $error("reset retriggered while busy");
    a_nak_start: assert property ($rose(usbNak) |-> $rose(phyRst))
        else $error("nak raised without reset");
    a_en_write: assert property (wr && addr == `PWRS_CTL_ADDR && !resumeDone |=>
        lanWakeEn == $past(wdata[3]) && edWakeEn == $past(wdata[2]))
        else $error("enable write lost");
    a_en_stable: assert property (!wr && !(resumeDone && resumeRemote) |=>
        $stable(lanWakeEn) && $stable(edWakeEn))
        else $error("enable changed without cause");
    c_reset_pulse: cover property ($fell(phyRst));
    c_remote_resume: cover property (resumeDone && resumeRemote);
    c_host_resume: cover property (resumeDone && !resumeRemote);
endmodule : pwrs_ctl_props

bind pwrs_ctl pwrs_ctl_props #(.HOLD_CYC(HOLD_CYC)) u_props (.*);

// ---- tb/pwrs_wake_model.sv ----
module pwrs_wake_model
    import pwrs_pkg::*;
(
    input wire logic   mclk,    // clock
    input wire logic   fireLan, // lan event request
    input wire logic   fireEd,  // energy event request
    input wire logic   fireRes, // resume request
    input wire logic   remote,  // resume kind for request
    output pwrs_wake_t wk       // events toward the block
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] lanQ = '0; // lan event stretch
    logic [1:0] edQ  = '0; // energy event stretch
    logic       togQ = 1'b0; // filler while kind is meaningless
    // stretch events so the two-stage sync cannot miss them
    always @(posedge mclk) begin
        lanQ <= {lanQ[0], fireLan};
        edQ  <= {edQ[0], fireEd};
        togQ <= ~togQ;
    end
    // kind only valid beside the pulse, otherwise it keeps moving
    always_comb begin
        wk.lanWake      = fireLan | (lanQ != 2'h0);
        wk.energyWake   = fireEd | (edQ != 2'h0);
        wk.resumeDone   = fireRes;
        wk.resumeRemote = fireRes ? remote : togQ;
    end
endmodule : pwrs_wake_model
